// file: src/lcs_top.sv
// Line card switch controller: control memory access, C/I change queue,
// D-channel arbiter enables, HDLC transmit steering and interrupts.
// Assumes an AXI4-Lite master on clk; subscriber, PCM and HDLC sides
// are logic on the same clock.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps

module lcs_top (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic                     irq,
   input  wire logic                ci_up_valid,
   input  wire logic [2:0]          ci_up_chan,
   input  wire logic [3:0]          ci_up_code,
   output logic [31:0]              ci_dn_codes,
   input  wire logic                sub_up_valid,
   input  wire logic [4:0]          sub_up_slot,
   input  wire logic [7:0]          sub_up_data,
   output logic                     pcm_tx_valid,
   output logic [4:0]               pcm_tx_slot,
   output logic [7:0]               pcm_tx_data,
   output logic                     pcm_tx_oe,
   input  wire logic                sub_dn_req,
   input  wire logic [4:0]          sub_dn_slot,
   output logic                     sub_dn_valid,
   output logic [4:0]               sub_dn_src,
   output logic                     hdlc_tx_valid,
   input  wire logic                hdlc_tx_ready,
   output logic [7:0]               hdlc_tx_data,
   output logic                     hdlc_tx_last,
   output logic [2:0]               hdlc_tx_chan,
   input  wire logic                hdlc_rx_valid,
   output logic                     hdlc_rx_ready,
   input  wire logic [7:0]          hdlc_rx_data,
   input  wire logic                hdlc_rx_last
);
   import lcs_pkg::*;

   logic                 aw_have_r, w_have_r, bvalid_r, rvalid_r;
   logic [7:0]           awaddr_r;
   logic [31:0]          wdata_r, rdata_r, rd_val;
   logic [3:0]           wstrb_r;
   logic [1:0]           bresp_r, rresp_r;
   logic                 wr_fire, rd_fire, rd_err, wr_known;
   logic [7:0]           acc_data_r, acc_addr_r, arb_en_r, dest_r, mask_r, sta_r, sta_set;
   logic [31:0]          tri_r, ci_dn_r;
   logic                 cmd_go, fetch_r, fetch_ci_r, up_ci_sel;
   logic [7:0]           cmd_val;
   logic [3:0]           up_ci_r [LCS_NCH];
   logic [3:0]           dn_ci_r [LCS_NCH];
   lcs_cmem_word_s       wword;
   lcs_cmem_word_s [2:0] rword;
   logic [2:0][7:0]      raddr;
   logic                 we_data, we_code;
   logic                 chg_push, chg_empty, chg_full;
   logic [7:0]           chg_dout;
   logic [4:0]           chg_cnt, tx_cnt, rx_cnt;
   logic                 tx_empty, tx_full, tx_busy_r, tx_pop, pool_set;
   logic                 rx_full, rx_empty, rx_push;
   logic [7:0]           tx_dout, rx_dout;
   logic                 up_v_r, dn_v_r, pcm_v_r, pcm_oe_r, sdn_v_r;
   logic [7:0]           up_d_r, pcm_d_r;
   logic [4:0]           pcm_s_r, sdn_s_r;

   function automatic logic hw(input logic [7:0] a);
      return wr_fire && wstrb_r[0] && awaddr_r == a;
   endfunction : hw

   function automatic logic hr(input logic [7:0] a);
      return rd_fire && s_axi_araddr == a;
   endfunction : hr

   // PCM slot named by a control memory data byte
   function automatic logic [4:0] pcm_slot(input logic [7:0] d);
      return {d[6:3], d[0]};
   endfunction : pcm_slot

   // Write channel
   assign s_axi_awready = !aw_have_r;
   assign s_axi_wready  = !w_have_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign wr_fire       = aw_have_r && w_have_r && !bvalid_r;
   assign wr_known      = awaddr_r <= LCS_A_PCM_TRI && awaddr_r[1:0] == 2'b00;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= LCS_RESP_OKAY;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
      end else begin
         if (s_axi_awvalid && !aw_have_r) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_r) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= wr_known ? LCS_RESP_OKAY : LCS_RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read channel
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign rd_fire       = s_axi_arvalid && !rvalid_r;

   always_comb begin
      rd_val = '0;
      rd_err = 1'b0;
      unique case (s_axi_araddr)
         LCS_A_ACC_DATA: rd_val[7:0] = acc_data_r;
         LCS_A_ACC_ADDR: rd_val[7:0] = acc_addr_r;
         LCS_A_ACC_CMD:  rd_val[7:0] = '0;
         LCS_A_EXT_STA:  rd_val[LCS_BIT_CHG] = !chg_empty;
         LCS_A_CHG_FIFO: rd_val[7:0] = chg_empty ? 8'h00 : chg_dout;
         LCS_A_ARB_EN:   rd_val[7:0] = arb_en_r;
         LCS_A_TX_DEST:  rd_val[7:0] = dest_r;
         LCS_A_HDLC_CMD: rd_val[7:0] = {7'h00, tx_busy_r};
         LCS_A_HDLC_STA: rd_val[7:0] = sta_r;
         LCS_A_IRQ_MASK: rd_val[7:0] = mask_r;
         LCS_A_TX_FIFO:  rd_val[4:0] = tx_cnt;
         LCS_A_RX_FIFO:  rd_val[7:0] = rx_empty ? 8'h00 : rx_dout;
         LCS_A_PCM_TRI:  rd_val = tri_r;
         default:        rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= LCS_RESP_OKAY;
      end else if (rd_fire) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_val;
         rresp_r  <= rd_err ? LCS_RESP_SLVERR : LCS_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Plain control registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         arb_en_r <= '0;
         dest_r   <= '0;
         mask_r   <= LCS_MASK_RESET;
         acc_addr_r <= '0;
      end else begin
         if (hw(LCS_A_ARB_EN)) begin
            arb_en_r <= wdata_r[7:0];
         end
         if (hw(LCS_A_TX_DEST)) begin
            dest_r <= wdata_r[7:0];
         end
         if (hw(LCS_A_IRQ_MASK)) begin
            mask_r <= wdata_r[7:0];
         end
         if (hw(LCS_A_ACC_ADDR)) begin
            acc_addr_r <= wdata_r[7:0];
         end
      end
   end

   // PCM tristate enables, all high impedance after reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tri_r <= '0;
      end else if (wr_fire && awaddr_r == LCS_A_PCM_TRI) begin
         for (int b = 0; b < 4; b++) begin
            if (wstrb_r[b]) begin
               tri_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
            end
         end
      end
   end

   // Memory access command
   assign cmd_go    = hw(LCS_A_ACC_CMD);
   assign cmd_val   = wdata_r[7:0];
   assign up_ci_sel = acc_addr_r[7] && acc_addr_r[3:2] == LCS_CI_SLOT && acc_addr_r[1:0] == 2'b00;
   assign we_data   = cmd_go && (cmd_val == LCS_CMD_WR_DATA || cmd_val[7:4] == LCS_CMD_WR_DC);
   assign we_code   = cmd_go && cmd_val[7:4] == LCS_CMD_WR_DC;
   assign wword     = '{code: cmd_val[3:0], data: acc_data_r};
   assign raddr[0]  = acc_addr_r;
   assign raddr[1]  = {1'b1, sub_up_slot, 2'b00};
   assign raddr[2]  = {1'b0, sub_dn_slot, 2'b00};

   lcs_cmem #(.NRD(3)) u_cmem (
      .clk     (clk),
      .resetn  (resetn),
      .we_data (we_data),
      .we_code (we_code),
      .waddr   (acc_addr_r),
      .wword   (wword),
      .raddr   (raddr),
      .rword   (rword)
   );

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fetch_r    <= 1'b0;
         fetch_ci_r <= 1'b0;
         acc_data_r <= '0;
      end else begin
         fetch_r    <= cmd_go && cmd_val == LCS_CMD_RD_DATA;
         fetch_ci_r <= up_ci_sel;
         if (hw(LCS_A_ACC_DATA)) begin
            acc_data_r <= wdata_r[7:0];
         end else if (fetch_r && fetch_ci_r) begin
            acc_data_r <= {LCS_CI_PAD, up_ci_r[acc_addr_r[6:4]], LCS_CI_PAD};
         end else if (fetch_r) begin
            acc_data_r <= rword[0].data;
         end
      end
   end

   // Command/indicate shadows; channel n sits in slot 4n+2, downstream in port 0 and upstream in port 1
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int c = 0; c < LCS_NCH; c++) begin
            up_ci_r[c] <= LCS_CI_RESET;
            dn_ci_r[c] <= LCS_CI_RESET;
         end
      end else begin
         if (ci_up_valid) begin
            up_ci_r[ci_up_chan] <= ci_up_code;
         end
         if (we_data && !acc_addr_r[7] && acc_addr_r[3:2] == LCS_CI_SLOT
             && acc_addr_r[1:0] == 2'b00) begin
            dn_ci_r[acc_addr_r[6:4]] <= acc_data_r[5:2];
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ci_dn_r <= {LCS_NCH{LCS_CI_RESET}};
      end else begin
         for (int c = 0; c < LCS_NCH; c++) begin
            ci_dn_r[c*4 +: 4] <= dn_ci_r[c] & ~(arb_en_r[c] ? LCS_ARB_MASK : 4'h0);
         end
      end
   end
   assign ci_dn_codes = ci_dn_r;

   // Change queue, one entry per change
   assign chg_push = ci_up_valid && ci_up_code != up_ci_r[ci_up_chan];

   lcs_fifo #(.W(8), .D(LCS_FIFO_D)) u_chg (
      .clk    (clk),
      .resetn (resetn),
      .flush  (1'b0),
      .push   (chg_push),
      .din    ({1'b1, ci_up_chan, LCS_CI_SLOT, 2'b00}),
      .pop    (hr(LCS_A_CHG_FIFO)),
      .dout   (chg_dout),
      .empty  (chg_empty),
      .full   (chg_full),
      .count  (chg_cnt)
   );

   // HDLC transmit
   assign hdlc_tx_valid = tx_busy_r && !tx_empty;
   assign hdlc_tx_last  = tx_cnt == 5'h01;
   assign hdlc_tx_data  = tx_dout;
   assign hdlc_tx_chan  = dest_r[2:0];
   assign tx_pop        = hdlc_tx_valid && hdlc_tx_ready;
   assign pool_set      = (tx_pop && hdlc_tx_last) || (tx_busy_r && tx_empty);

   lcs_fifo #(.W(8), .D(LCS_FIFO_D)) u_tx (
      .clk    (clk),
      .resetn (resetn),
      .flush  (1'b0),
      .push   (hw(LCS_A_TX_FIFO)),
      .din    (wdata_r[7:0]),
      .pop    (tx_pop),
      .dout   (tx_dout),
      .empty  (tx_empty),
      .full   (tx_full),
      .count  (tx_cnt)
   );

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_busy_r <= 1'b0;
      end else if (hw(LCS_A_HDLC_CMD) && cmd_val == LCS_CMD_XMIT) begin
         tx_busy_r <= 1'b1;
      end else if (pool_set) begin
         tx_busy_r <= 1'b0;
      end
   end

   // HDLC receive
   assign hdlc_rx_ready = !rx_full;
   assign rx_push       = hdlc_rx_valid && !rx_full;

   lcs_fifo #(.W(8), .D(LCS_FIFO_D)) u_rx (
      .clk    (clk),
      .resetn (resetn),
      .flush  (hw(LCS_A_HDLC_CMD) && cmd_val == LCS_CMD_RX_RST),
      .push   (rx_push),
      .din    (hdlc_rx_data),
      .pop    (hr(LCS_A_RX_FIFO)),
      .dout   (rx_dout),
      .empty  (rx_empty),
      .full   (rx_full),
      .count  (rx_cnt)
   );

   // Sticky status, cleared by read; a set in the same cycle wins
   always_comb begin
      sta_set = '0;
      sta_set[LCS_BIT_POOL]   = pool_set;
      sta_set[LCS_BIT_MSGEND] = rx_push && hdlc_rx_last;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sta_r <= '0;
      end else begin
         sta_r <= (hr(LCS_A_HDLC_STA) ? 8'h00 : sta_r) | sta_set;
      end
   end

   assign irq = |(sta_r & mask_r) || (!chg_empty && mask_r[LCS_BIT_CHG]);

   // Switching paths, two cycles from request to output
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         up_v_r   <= 1'b0;
         up_d_r   <= '0;
         dn_v_r   <= 1'b0;
         pcm_v_r  <= 1'b0;
         pcm_s_r  <= '0;
         pcm_d_r  <= '0;
         pcm_oe_r <= 1'b0;
         sdn_v_r  <= 1'b0;
         sdn_s_r  <= '0;
      end else begin
         up_v_r   <= sub_up_valid;
         up_d_r   <= sub_up_data;
         dn_v_r   <= sub_dn_req;
         pcm_v_r  <= up_v_r && rword[1].code == LCS_CODE_64K;
         pcm_s_r  <= pcm_slot(rword[1].data);
         pcm_d_r  <= up_d_r;
         pcm_oe_r <= up_v_r && rword[1].code == LCS_CODE_64K
                     && tri_r[pcm_slot(rword[1].data)];
         sdn_v_r  <= dn_v_r && rword[2].code == LCS_CODE_64K;
         sdn_s_r  <= pcm_slot(rword[2].data);
      end
   end

   assign pcm_tx_valid = pcm_v_r;
   assign pcm_tx_slot  = pcm_s_r;
   assign pcm_tx_data  = pcm_d_r;
   assign pcm_tx_oe    = pcm_oe_r;
   assign sub_dn_valid = sdn_v_r;
   assign sub_dn_src   = sdn_s_r;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_cmd(logic [7:0] c);
      cmd_go && cmd_val == c;
   endsequence

   a_data_write: assert property (s_cmd(LCS_CMD_WR_DATA) ##1 $stable(acc_addr_r)
      |-> ##1 rword[0].data == $past(acc_data_r, 2) || acc_addr_r != $past(acc_addr_r))
      else $error("data write not stored");
   a_code_write: assert property (s_cmd({LCS_CMD_WR_DC, LCS_CODE_64K}) ##1 $stable(acc_addr_r)
      |-> ##1 rword[0].code == LCS_CODE_64K || acc_addr_r != $past(acc_addr_r))
      else $error("64k code not stored");
   a_fetch_data: assert property (s_cmd(LCS_CMD_RD_DATA) && !up_ci_sel
      |-> ##2 acc_data_r == $past(rword[0].data) || $past(hw(LCS_A_ACC_DATA)))
      else $error("fetch did not load access data");
   a_ci_active_read: assert property (s_cmd(LCS_CMD_RD_DATA) && up_ci_sel
      && up_ci_r[acc_addr_r[6:4]] == 4'hC ##1 !$past(ci_up_valid)
      |-> ##1 acc_data_r == 8'hF3 || $past(hw(LCS_A_ACC_DATA)))
      else $error("active indication not read as F3");
   a_chg_irq: assert property (!chg_empty && mask_r[LCS_BIT_CHG] |-> irq)
      else $error("change queue not signalled");
   a_chg_queue: assert property (chg_push && !chg_full && !hr(LCS_A_CHG_FIFO)
      |=> chg_cnt == $past(chg_cnt) + 5'h01)
      else $error("change not queued");
   a_irq_release: assert property (chg_empty && (sta_r & mask_r) == 8'h00 |-> !irq)
      else $error("interrupt held with nothing pending");
   a_arb_avail: assert property (arb_en_r[1] && $past(arb_en_r[1]) |-> !ci_dn_codes[6])
      else $error("arbitration bit not available");
   a_pool_ready: assert property (tx_pop && hdlc_tx_last
      |=> sta_r[LCS_BIT_POOL] && (irq || !mask_r[LCS_BIT_POOL]))
      else $error("pool ready missing");
   a_msg_end: assert property (rx_push && hdlc_rx_last |=> sta_r[LCS_BIT_MSGEND])
      else $error("message end missing");
   a_tx_start: assert property (hw(LCS_A_HDLC_CMD) && cmd_val == LCS_CMD_XMIT
      && !tx_empty |=> hdlc_tx_valid)
      else $error("transmit not started");
   a_hiz_slot: assert property (tri_r == 32'h0 && $past(tri_r) == 32'h0 |-> !pcm_tx_oe)
      else $error("high impedance slot driven");
endmodule : lcs_top

// file: include/lcs_pkg.sv
// Shared constants and types for the line card switch controller.
// Assumes a 32-bit AXI4-Lite master and one 50 MHz clock.
package lcs_pkg;
   // Register byte offsets
   localparam logic [7:0] LCS_A_ACC_DATA  = 8'h00;
   localparam logic [7:0] LCS_A_ACC_ADDR  = 8'h04;
   localparam logic [7:0] LCS_A_ACC_CMD   = 8'h08;
   localparam logic [7:0] LCS_A_EXT_STA   = 8'h0C;
   localparam logic [7:0] LCS_A_CHG_FIFO  = 8'h10;
   localparam logic [7:0] LCS_A_ARB_EN    = 8'h14;
   localparam logic [7:0] LCS_A_TX_DEST   = 8'h18;
   localparam logic [7:0] LCS_A_HDLC_CMD  = 8'h1C;
   localparam logic [7:0] LCS_A_HDLC_STA  = 8'h20;
   localparam logic [7:0] LCS_A_IRQ_MASK  = 8'h24;
   localparam logic [7:0] LCS_A_TX_FIFO   = 8'h28;
   localparam logic [7:0] LCS_A_RX_FIFO   = 8'h2C;
   localparam logic [7:0] LCS_A_PCM_TRI   = 8'h30;
   // Memory access commands
   localparam logic [7:0] LCS_CMD_WR_DATA = 8'h48;
   localparam logic [7:0] LCS_CMD_RD_DATA = 8'hC8;
   localparam logic [3:0] LCS_CMD_WR_DC   = 4'h7;
   localparam logic [3:0] LCS_CODE_64K    = 4'h1;
   // HDLC commands
   localparam logic [7:0] LCS_CMD_XMIT    = 8'h0A;
   localparam logic [7:0] LCS_CMD_RX_RST  = 8'h80;
   // Status bit positions
   localparam int         LCS_BIT_POOL   = 4;
   localparam int         LCS_BIT_CHG    = 6;
   localparam int         LCS_BIT_MSGEND = 7;
   // Command/indicate handling
   localparam logic [3:0] LCS_CI_RESET    = 4'hF;
   localparam logic [3:0] LCS_ARB_MASK    = 4'h4;
   localparam logic [1:0] LCS_CI_SLOT     = 2'b10;
   localparam logic [1:0] LCS_CI_PAD      = 2'b11;
   localparam logic [7:0] LCS_MASK_RESET  = 8'hFF;
   localparam int         LCS_NCH         = 8;
   localparam int         LCS_FIFO_D      = 16;
   // Bus answers
   localparam logic [1:0] LCS_RESP_OKAY   = 2'b00;
   localparam logic [1:0] LCS_RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [3:0] code;
      logic [7:0] data;
   } lcs_cmem_word_s;
endpackage : lcs_pkg

// file: src/lcs_cmem.sv
// Switch control memory: 256 words, split write enables, registered reads.
// Assumes one clock; read data lag the address by one edge.
`timescale 1ns/100ps
module lcs_cmem #(parameter int NRD = 3) (
   input  wire logic                            clk,
   input  wire logic                            resetn,
   input  wire logic                            we_data,
   input  wire logic                            we_code,
   input  wire logic [7:0]                      waddr,
   input  wire lcs_pkg::lcs_cmem_word_s         wword,
   input  wire logic [NRD-1:0][7:0]             raddr,
   output lcs_pkg::lcs_cmem_word_s [NRD-1:0]    rword
);
   import lcs_pkg::*;

   lcs_cmem_word_s mem_r [256];

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 256; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         if (we_data) begin
            mem_r[waddr].data <= wword.data;
         end
         if (we_code) begin
            mem_r[waddr].code <= wword.code;
         end
      end
   end

   for (genvar g = 0; g < NRD; g++) begin : g_rd
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            rword[g] <= '0;
         end else begin
            rword[g] <= mem_r[raddr[g]];
         end
      end
   end
endmodule : lcs_cmem

// file: src/lcs_fifo.sv
// Small synchronous FIFO with flush; full pushes and empty pops are ignored.
// Assumes one clock; dout shows the oldest entry.
`timescale 1ns/100ps
module lcs_fifo #(parameter int W = 8, parameter int D = 16) (
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic                   flush,
   input  wire logic                   push,
   input  wire logic [W-1:0]           din,
   input  wire logic                   pop,
   output logic [W-1:0]                dout,
   output logic                        empty,
   output logic                        full,
   output logic [$clog2(D):0]          count
);
   localparam int AW = $clog2(D);

   logic [W-1:0]  mem_r [D];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0]   cnt_r;
   logic          do_push;
   logic          do_pop;

   assign empty   = cnt_r == '0;
   assign full    = cnt_r == (AW+1)'(D);
   assign count   = cnt_r;
   assign dout    = mem_r[rp_r];
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;

   always_ff @(posedge clk) begin
      if (do_push) begin
         mem_r[wp_r] <= din;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else if (flush) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= do_push ? wp_r + 1'b1 : wp_r;
         rp_r  <= do_pop ? rp_r + 1'b1 : rp_r;
         cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule : lcs_fifo

// file: testbench/lcs_far.sv
// Far HDLC side: transmit sink that stalls every other cycle, 3-byte frames.
// Assumes the HDLC ports of the top module on one clock.
`timescale 1ns/100ps
module lcs_far (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       hdlc_tx_valid,
   input  wire logic       hdlc_rx_ready,
   input  wire logic       rx_go,
   output logic            hdlc_tx_ready,
   output logic [3:0]      tx_n,
   output logic            hdlc_rx_valid,
   output logic [7:0]      hdlc_rx_data,
   output logic            hdlc_rx_last
);
   logic [1:0] left_r;
   assign hdlc_rx_valid = left_r != 2'h0;
   assign hdlc_rx_last = left_r == 2'h1;
   assign hdlc_rx_data = hdlc_rx_valid ? {6'h2A, left_r} : 8'h56;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hdlc_tx_ready <= 1'b0;
         tx_n <= 4'h0;
         left_r <= 2'h0;
      end else begin
         hdlc_tx_ready <= ~hdlc_tx_ready;
         if (hdlc_tx_valid && hdlc_tx_ready) tx_n <= tx_n + 4'h1;
         if (hdlc_rx_valid && hdlc_rx_ready) left_r <= left_r - 2'h1;
         else if (rx_go && !hdlc_rx_valid) left_r <= 2'h3;
      end
   end
endmodule : lcs_far

// file: testbench/lcs_top_tb_top.sv
// Register-level bench of the switch controller over AXI4-Lite.
// Assumes lcs_far on the HDLC side; bench drives C/I and slot requests.
`timescale 1ns/100ps
module lcs_top_tb_top;
   import lcs_pkg::*;
   logic clk = 0, resetn = 0, irq, rx_go = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, ci_up_valid = 0, sub_up_valid = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pcm_tx_data, hdlc_tx_data, hdlc_rx_data;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, ci_dn_codes;
   logic [3:0] s_axi_wstrb = 4'hF, ci_up_code = 0, tx_n;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic sub_dn_req = 0, pcm_tx_valid, pcm_tx_oe, sub_dn_valid, hdlc_tx_valid, hdlc_tx_ready;
   logic hdlc_tx_last, hdlc_rx_valid, hdlc_rx_ready, hdlc_rx_last;
   logic [2:0] ci_up_chan = 0, hdlc_tx_chan;
   logic [4:0] sub_up_slot = 0, pcm_tx_slot, sub_dn_slot = 0, sub_dn_src;
   logic [7:0] sub_up_data = 0;
   int n_fail = 0, checks = 0, cyc = 0;
   lcs_top u_lcs_top (.*);
   lcs_far u_lcs_far (.*);
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] s, e);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d);
      logic aw, w, b;
      b = 0;
      @(posedge clk);
      s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      while (!b) begin
         @(negedge clk);
         aw = s_axi_awready === 1'b1; w = s_axi_wready === 1'b1; b = s_axi_bvalid === 1'b1;
         if (b) rr = s_axi_bresp;
         @(posedge clk);
         if (aw) s_axi_awvalid <= 0;
         if (w) s_axi_wvalid <= 0;
         if (b) s_axi_bready <= 0;
      end
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic ar, r;
      r = 0;
      @(posedge clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      while (!r) begin
         @(negedge clk);
         ar = s_axi_arready === 1'b1; r = s_axi_rvalid === 1'b1; rr = s_axi_rresp;
         if (r) chk($sformatf("rd %h", a), s_axi_rdata, e);
         @(posedge clk);
         if (ar) s_axi_arvalid <= 0;
         if (r) s_axi_rready <= 0;
      end
   endtask : rdc
   task automatic mop(input logic [7:0] dt, ad, cm);
      wr(LCS_A_ACC_DATA, dt);
      wr(LCS_A_ACC_ADDR, ad);
      wr(LCS_A_ACC_CMD, cm);
   endtask : mop
   task automatic wv(input int k);
      for (int i = 0; i < 60; i++) begin
         @(negedge clk);
         if ((k == 0 ? irq : k == 1 ? sub_dn_valid : pcm_tx_valid) === 1'b1) break;
      end
   endtask : wv
   task automatic pulse(input int k, input logic [4:0] s);
      @(posedge clk);
      if (k == 0) begin ci_up_valid <= 1; ci_up_chan <= 1; ci_up_code <= s[3:0]; end
      if (k == 1) begin sub_dn_req <= 1; sub_dn_slot <= s; end
      if (k == 2) begin sub_up_valid <= 1; sub_up_slot <= s; sub_up_data <= 8'h5C; end
      @(posedge clk);
      ci_up_valid <= 0; sub_dn_req <= 0; sub_up_valid <= 0;
      if (k > 0) wv(k);
   endtask : pulse
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1;
      chk("dn", ci_dn_codes, 32'hFFFFFFFF);
      mop(8'hF3, 8'h18, LCS_CMD_WR_DATA);
      repeat (3) @(negedge clk);
      chk("dn1", ci_dn_codes[7:4], 4'hC);
      wr(LCS_A_ARB_EN, 8'h03);
      repeat (3) @(negedge clk);
      chk("arb", ci_dn_codes[7:0], 8'h8B);
      pulse(0, 5'hC); pulse(0, 5'hD); pulse(0, 5'hC); pulse(0, 5'hC);
      rdc(LCS_A_EXT_STA, 32'h40);
      chk("irq", irq, 1'b1);
      repeat (3) rdc(LCS_A_CHG_FIFO, 32'h98);
      chk("irq", irq, 1'b0);
      wr(LCS_A_ACC_ADDR, 8'h98);
      wr(LCS_A_ACC_CMD, LCS_CMD_RD_DATA);
      rdc(LCS_A_ACC_DATA, 32'hF3);
      $display("test ci done");
      mop(8'h08, 8'h00, {LCS_CMD_WR_DC, LCS_CODE_64K});
      mop(8'h01, 8'h10, {LCS_CMD_WR_DC, LCS_CODE_64K});
      pulse(1, 5'd0); chk("src", {sub_dn_valid, sub_dn_src}, 6'h22);
      pulse(1, 5'd4); chk("src", {sub_dn_valid, sub_dn_src}, 6'h21);
      wr(LCS_A_ACC_ADDR, 8'h00);
      wr(LCS_A_ACC_CMD, LCS_CMD_RD_DATA);
      rdc(LCS_A_ACC_DATA, 32'h08);
      mop(8'h81, 8'h80, {LCS_CMD_WR_DC, LCS_CODE_64K});
      pulse(2, 5'd0); chk("pcm", {pcm_tx_valid, pcm_tx_slot, pcm_tx_oe, pcm_tx_data}, 15'h425C);
      wr(LCS_A_PCM_TRI, 8'h02);
      pulse(2, 5'd0); chk("pcm", {pcm_tx_valid, pcm_tx_slot, pcm_tx_oe, pcm_tx_data}, 15'h435C);
      $display("test switch done");
      wr(LCS_A_TX_DEST, 8'h01);
      repeat (2) @(negedge clk);
      chk("chan", hdlc_tx_chan, 3'h1);
      chk("bok", rr, LCS_RESP_OKAY);
      wr(LCS_A_TX_FIFO, 8'hA1); wr(LCS_A_TX_FIFO, 8'hA2);
      chk("txd", {hdlc_tx_valid, hdlc_tx_last, hdlc_tx_data}, 10'h0A1);
      wr(LCS_A_HDLC_CMD, LCS_CMD_XMIT);
      wv(0); rdc(LCS_A_HDLC_STA, 32'h10);
      chk("txn", tx_n, 4'h2);
      rdc(LCS_A_HDLC_STA, 32'h0);
      @(posedge clk) rx_go <= 1;
      @(posedge clk) rx_go <= 0;
      wv(0); rdc(LCS_A_HDLC_STA, 32'h80);
      rdc(LCS_A_RX_FIFO, 32'hAB);
      wr(LCS_A_HDLC_CMD, LCS_CMD_RX_RST);
      rdc(LCS_A_RX_FIFO, 32'h0);
      rdc(8'h3C, 32'h0); chk("resp", rr, LCS_RESP_SLVERR);
      wr(8'h3C, 8'h00); chk("bresp", rr, LCS_RESP_SLVERR);
      $display("test hdlc done");
      final_report();
   end
endmodule : lcs_top_tb_top
